/* serial_port_pkg.sv */
// Contract
// - separate transmit and receive buffers, each holding up to 16 characters
// - character length of 5, 6, 7 or 8 data bits both ways
// - parity generated on transmit and checked on receive: even, odd or none
// - start and stop bits made and detected; one or two stop bits
// - drive a break on the output and detect a break on the input
// - bit rate is clock divided by sixteen times the external divisor
// - software enables both buffers; receive side has a trigger level
// - with buffers off, each path holds exactly one character
// - after reset holding-empty status bit 5 is set, transmit interrupt pending but masked
// - transmit interrupt while nothing waits; maskable; cleared by a data write
// - shift out lsb first with framing; output idles at logic 1
// - serial output advances one bit every 16 bit-rate enables
// - data-ready bit 0 set on receive, cleared once every character is read
// - received characters shorter than eight bits have zero upper bits
// - receiver samples at 16x and aligns to start bit falling edge
// - flag parity, framing, overrun and break errors on the input
// - two handshake outputs, four inputs; change flags; ring on trailing edge
// - loop mode routes serial and handshake signals back internally
// - receive interrupt at count reaching trigger, or one character unbuffered
// - time-out after four idle character times below trigger; cleared when empty
// - receive data and time-out interrupts share one enable bit
// - line status interrupt while head character has an error; status read clears
// - summary error bit stays set while any errored character is buffered
package serial_port_pkg;
  // ==========================================================
  // register byte addresses
  localparam logic [7:0] data_adr = 8'h00;
  localparam logic [7:0] int_enable_adr = 8'h04;
  localparam logic [7:0] int_pending_adr = 8'h08;
  localparam logic [7:0] line_control_adr = 8'h0c;
  localparam logic [7:0] modem_control_adr = 8'h10;
  localparam logic [7:0] line_status_adr = 8'h14;
  localparam logic [7:0] modem_status_adr = 8'h18;
  // ==========================================================
  // field positions
  localparam int ie_rx = 0;
  localparam int ie_tx = 1;
  localparam int ie_ls = 2;
  localparam int ie_ms = 3;
  localparam int lc_len = 0;
  localparam int lc_stop2 = 2;
  localparam int lc_par_en = 3;
  localparam int lc_even = 4;
  localparam int lc_break = 5;
  localparam int lc_fifo_en = 6;
  localparam int lc_trig = 7;
  localparam int mc_dtr = 0;
  localparam int mc_rts = 1;
  localparam int mc_out1 = 2;
  localparam int mc_out2 = 3;
  localparam int mc_loop = 4;
  localparam int ls_ready = 0;
  localparam int ls_overrun = 1;
  localparam int ls_parity = 2;
  localparam int ls_framing = 3;
  localparam int ls_break = 4;
  localparam int ls_holding_empty = 5;
  localparam int ls_tx_idle = 6;
  localparam int ls_error = 7;
  // ==========================================================
  // reset values and counts
  localparam logic [8:0] line_control_rst = 9'h003;
  localparam logic [3:0] int_enable_rst = 4'h0;
  localparam logic [4:0] modem_control_rst = 5'h00;
  localparam logic [3:0] ticks_last = 4'hf;
  localparam logic [3:0] ticks_half = 4'h7;
  localparam int ticks_per_bit = 16;
  localparam int timeout_chars = 4;
  localparam logic [4:0] trig_1 = 5'h01;
  localparam logic [4:0] trig_4 = 5'h04;
  localparam logic [4:0] trig_8 = 5'h08;
  localparam logic [4:0] trig_14 = 5'h0e;

  typedef enum logic [2:0] {
    ser_idle, ser_start, ser_data, ser_parity, ser_stop
  } ser_state_t;
endpackage

/* serial_port.sv */
`timescale 1ns/1ps
module serial_port #(
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // 16x bit-rate enable from the external divider
  input wire logic bit_rate_tick_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // serial line
  input wire logic rxd_i,
  output logic txd_o,
  // handshake, active low on the pins
  input wire logic cts_n_i,
  input wire logic dsr_n_i,
  input wire logic ring_indicate_n_i,
  input wire logic dcd_n_i,
  output logic rts_n_o,
  output logic dtr_n_o,
  // interrupt
  output logic irq_o
);
  typedef struct packed {
    logic [DEPTH-1:0][7:0] txm;
    logic [AW-1:0] tx_rd;
    logic [AW-1:0] tx_wr;
    logic [AW:0] tx_cnt;
    logic [DEPTH-1:0][10:0] rxm;
    logic [AW-1:0] rx_rd;
    logic [AW-1:0] rx_wr;
    logic [AW:0] rx_cnt;
    logic [3:0] ie;
    logic [8:0] lc;
    logic [4:0] mc;
    logic overrun;
    logic head_seen;
    logic [3:0] msd;
    logic [3:0] ms_prev;
    serial_port_pkg::ser_state_t tx_st;
    logic [3:0] tx_tk;
    logic [2:0] tx_bit;
    logic [7:0] tx_sh;
    logic tx_par;
    serial_port_pkg::ser_state_t rx_st;
    logic [3:0] rx_tk;
    logic [2:0] rx_bit;
    logic [7:0] rx_sh;
    logic rx_pe;
    logic rx_zero;
    logic rx_prev;
    logic [9:0] to_cnt;
    logic to_flag;
    logic txd;
    logic ack;
    logic [31:0] dat;
    logic irq;
  } state_t;

  state_t s_r, s_nxt;
  logic [DEPTH-1:0] err_v;
  logic [3:0] ms_now;
  logic rxi;

  // ==========================================================
  // loopback routing and per-entry error scan
  assign rxi = s_r.mc[serial_port_pkg::mc_loop] ? s_r.txd : rxd_i;
  assign ms_now = s_r.mc[serial_port_pkg::mc_loop] ?
    {s_r.mc[serial_port_pkg::mc_out2], s_r.mc[serial_port_pkg::mc_out1],
     s_r.mc[serial_port_pkg::mc_dtr], s_r.mc[serial_port_pkg::mc_rts]} :
    {~dcd_n_i, ~ring_indicate_n_i, ~dsr_n_i, ~cts_n_i};

  // depth must be a power of two so the offset wraps correctly
  for (genvar i = 0; i < DEPTH; i++) begin : g_err
    logic [AW-1:0] offs;
    assign offs = AW'(i) - s_r.rx_rd;
    assign err_v[i] = (|s_r.rxm[i][10:8]) &&
                      ({1'b0, offs} < s_r.rx_cnt);
  end

  // ==========================================================
  // next state
  always_comb begin
    logic acc, wr, rd, tx_push, tx_pop, rx_push, rx_pop, tk;
    logic [AW:0] cap;
    logic [4:0] trig;
    logic [2:0] lenm1;
    logic [7:0] mask, wd;
    logic [9:0] to_lim;
    logic [10:0] rx_word;
    logic pend_rx, pend_tx, pend_ls, pend_ms, pend_to;
    acc = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    tx_push = 1'b0;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    rx_pop = 1'b0;
    rx_word = 11'h000;
    wd = 8'h00;
    s_nxt = s_r;
    tk = bit_rate_tick_i;
    lenm1 = {1'b1, s_r.lc[serial_port_pkg::lc_len +: 2]};
    mask = 8'hff >> (3'h3 - s_r.lc[serial_port_pkg::lc_len +: 2]);
    cap = s_r.lc[serial_port_pkg::lc_fifo_en] ?
          (AW+1)'(DEPTH) : (AW+1)'(1);
    case (s_r.lc[serial_port_pkg::lc_trig +: 2])
      2'h0: trig = serial_port_pkg::trig_1;
      2'h1: trig = serial_port_pkg::trig_4;
      2'h2: trig = serial_port_pkg::trig_8;
      default: trig = serial_port_pkg::trig_14;
    endcase
    if (!s_r.lc[serial_port_pkg::lc_fifo_en]) begin
      trig = serial_port_pkg::trig_1;
    end
    // frame is start, data, optional parity and the stop bits
    to_lim = 10'(serial_port_pkg::timeout_chars *
      serial_port_pkg::ticks_per_bit) *
      (10'h3 + 10'(lenm1) + 10'(s_r.lc[serial_port_pkg::lc_par_en]) +
       10'(s_r.lc[serial_port_pkg::lc_stop2]));

    // ---------------- bus slave: one wait state, then ack
    s_nxt.ack = 1'b0;
    if (wb_cyc_i && wb_stb_i && !s_r.ack) begin
      acc = 1'b1;
      s_nxt.ack = 1'b1;
      wr = wb_we_i && wb_sel_i[0];
      rd = !wb_we_i;
      wd = wb_dat_i[7:0];
    end
    s_nxt.dat = 32'h0000_0000;
    if (acc && rd) begin
      case (wb_adr_i)
        serial_port_pkg::data_adr: begin
          s_nxt.dat[10:0] = {3'h0, s_r.rxm[s_r.rx_rd][7:0]};
          rx_pop = s_r.rx_cnt != '0;
        end
        serial_port_pkg::int_enable_adr: s_nxt.dat[3:0] = s_r.ie;
        serial_port_pkg::int_pending_adr:
          s_nxt.dat[4:0] = {s_r.msd != '0, s_r.irq, s_r.to_flag,
                            s_r.tx_cnt == '0, s_r.rx_cnt >= trig};
        serial_port_pkg::line_control_adr: s_nxt.dat[8:0] = s_r.lc;
        serial_port_pkg::modem_control_adr: s_nxt.dat[4:0] = s_r.mc;
        serial_port_pkg::line_status_adr: begin
          s_nxt.dat[7:0] = {|err_v,
            s_r.tx_cnt == '0 && s_r.tx_st == serial_port_pkg::ser_idle,
            s_r.tx_cnt == '0,
            s_r.rx_cnt != '0 ? s_r.rxm[s_r.rx_rd][10:8] : 3'h0,
            s_r.overrun, s_r.rx_cnt != '0};
          s_nxt.overrun = 1'b0;
          s_nxt.head_seen = 1'b1;
        end
        serial_port_pkg::modem_status_adr: begin
          s_nxt.dat[7:0] = {s_r.ms_prev, s_r.msd};
          s_nxt.msd = 4'h0;
        end
        default: s_nxt.dat = 32'h0000_0000;
      endcase
    end
    if (wr) begin
      case (wb_adr_i)
        serial_port_pkg::data_adr: tx_push = s_r.tx_cnt < cap;
        serial_port_pkg::int_enable_adr: s_nxt.ie = wd[3:0];
        serial_port_pkg::line_control_adr:
          s_nxt.lc = {wb_dat_i[8], wd};
        serial_port_pkg::modem_control_adr: s_nxt.mc = wd[4:0];
        default: s_nxt.mc = s_nxt.mc;
      endcase
    end

    // ---------------- transmitter
    if (s_r.tx_st == serial_port_pkg::ser_idle) begin
      if (s_r.tx_cnt != '0) begin
        tx_pop = 1'b1;
        s_nxt.tx_sh = s_r.txm[s_r.tx_rd] & mask;
        s_nxt.tx_par = ^(s_r.txm[s_r.tx_rd] & mask) ^
                       ~s_r.lc[serial_port_pkg::lc_even];
        s_nxt.tx_st = serial_port_pkg::ser_start;
        s_nxt.tx_tk = 4'h0;
        s_nxt.tx_bit = 3'h0;
      end
    end else if (tk) begin
      s_nxt.tx_tk = s_r.tx_tk + 4'h1;
      if (s_r.tx_tk == serial_port_pkg::ticks_last) begin
        case (s_r.tx_st)
          serial_port_pkg::ser_start:
            s_nxt.tx_st = serial_port_pkg::ser_data;
          serial_port_pkg::ser_data: begin
            s_nxt.tx_sh = s_r.tx_sh >> 1;
            s_nxt.tx_bit = s_r.tx_bit + 3'h1;
            if (s_r.tx_bit == lenm1) begin
              s_nxt.tx_bit = 3'h0;
              s_nxt.tx_st = s_r.lc[serial_port_pkg::lc_par_en] ?
                serial_port_pkg::ser_parity : serial_port_pkg::ser_stop;
            end
          end
          serial_port_pkg::ser_parity:
            s_nxt.tx_st = serial_port_pkg::ser_stop;
          serial_port_pkg::ser_stop: begin
            s_nxt.tx_bit = 3'h1;
            if (s_r.tx_bit == 3'(s_r.lc[serial_port_pkg::lc_stop2])) begin
              s_nxt.tx_st = serial_port_pkg::ser_idle;
            end
          end
          default: s_nxt.tx_st = serial_port_pkg::ser_idle;
        endcase
      end
    end
    case (s_nxt.tx_st)
      serial_port_pkg::ser_start: s_nxt.txd = 1'b0;
      serial_port_pkg::ser_data: s_nxt.txd = s_nxt.tx_sh[0];
      serial_port_pkg::ser_parity: s_nxt.txd = s_nxt.tx_par;
      default: s_nxt.txd = 1'b1;
    endcase
    if (s_nxt.lc[serial_port_pkg::lc_break]) begin
      s_nxt.txd = 1'b0;
    end

    // ---------------- receiver
    s_nxt.rx_prev = rxi;
    case (s_r.rx_st)
      serial_port_pkg::ser_idle:
        if (!rxi && s_r.rx_prev) begin
          s_nxt.rx_st = serial_port_pkg::ser_start;
          s_nxt.rx_tk = 4'h0;
        end
      serial_port_pkg::ser_start:
        if (tk) begin
          s_nxt.rx_tk = s_r.rx_tk + 4'h1;
          if (s_r.rx_tk == serial_port_pkg::ticks_half) begin
            s_nxt.rx_tk = 4'h0;
            s_nxt.rx_bit = 3'h0;
            s_nxt.rx_sh = 8'h00;
            s_nxt.rx_zero = 1'b1;
            s_nxt.rx_pe = 1'b0;
            s_nxt.rx_st = rxi ? serial_port_pkg::ser_idle :
                                serial_port_pkg::ser_data;
          end
        end
      default:
        if (tk) begin
          s_nxt.rx_tk = s_r.rx_tk + 4'h1;
          if (s_r.rx_tk == serial_port_pkg::ticks_last) begin
            s_nxt.rx_zero = s_r.rx_zero & ~rxi;
            if (s_r.rx_st == serial_port_pkg::ser_data) begin
              s_nxt.rx_sh[s_r.rx_bit] = rxi;
              s_nxt.rx_bit = s_r.rx_bit + 3'h1;
              if (s_r.rx_bit == lenm1) begin
                s_nxt.rx_st = s_r.lc[serial_port_pkg::lc_par_en] ?
                  serial_port_pkg::ser_parity : serial_port_pkg::ser_stop;
              end
            end else if (s_r.rx_st == serial_port_pkg::ser_parity) begin
              s_nxt.rx_pe = ^s_r.rx_sh ^ rxi ^
                            ~s_r.lc[serial_port_pkg::lc_even];
              s_nxt.rx_st = serial_port_pkg::ser_stop;
            end else begin
              rx_word = {s_r.rx_zero & ~rxi, ~rxi, s_r.rx_pe,
                         s_r.rx_sh};
              if (s_r.rx_cnt < cap) begin
                rx_push = 1'b1;
              end else begin
                s_nxt.overrun = 1'b1;
              end
              s_nxt.rx_st = serial_port_pkg::ser_idle;
            end
          end
        end
    endcase

    // ---------------- buffer bookkeeping
    if (tx_push) begin
      s_nxt.txm[s_r.tx_wr] = wd;
      s_nxt.tx_wr = s_r.tx_wr + 1'b1;
    end
    if (tx_pop) begin
      s_nxt.tx_rd = s_r.tx_rd + 1'b1;
    end
    s_nxt.tx_cnt = s_r.tx_cnt + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
    if (rx_push) begin
      s_nxt.rxm[s_r.rx_wr] = rx_word;
      s_nxt.rx_wr = s_r.rx_wr + 1'b1;
    end
    if (rx_pop) begin
      s_nxt.rx_rd = s_r.rx_rd + 1'b1;
    end
    // a new head character must raise its own line status interrupt
    if (rx_pop || (rx_push && s_r.rx_cnt == '0)) begin
      s_nxt.head_seen = 1'b0;
    end
    s_nxt.rx_cnt = s_r.rx_cnt + (AW+1)'(rx_push) - (AW+1)'(rx_pop);

    // ---------------- time-out
    if (rx_push || rx_pop || s_r.rx_cnt == '0) begin
      s_nxt.to_cnt = 10'h000;
    end else if (tk && s_r.to_cnt != to_lim) begin
      s_nxt.to_cnt = s_r.to_cnt + 10'h001;
    end
    if (s_r.to_cnt == to_lim && s_r.rx_cnt < trig && s_r.rx_cnt != '0) begin
      s_nxt.to_flag = 1'b1;
    end else if (s_nxt.rx_cnt == '0) begin
      s_nxt.to_flag = 1'b0;
    end

    // ---------------- handshake change flags, set wins over read
    s_nxt.ms_prev = ms_now;
    s_nxt.msd = s_nxt.msd | {ms_now[3] ^ s_r.ms_prev[3],
      s_r.ms_prev[2] & ~ms_now[2], ms_now[1:0] ^ s_r.ms_prev[1:0]};

    // ---------------- interrupt summary
    pend_rx = s_nxt.rx_cnt >= trig && s_nxt.rx_cnt != '0;
    pend_to = s_nxt.to_flag;
    pend_tx = s_nxt.tx_cnt == '0;
    pend_ls = s_nxt.overrun || (!s_nxt.head_seen && s_nxt.rx_cnt != '0 &&
              |s_nxt.rxm[s_nxt.rx_rd][10:8]);
    pend_ms = s_nxt.msd != '0;
    s_nxt.irq = (s_nxt.ie[serial_port_pkg::ie_rx] &&
                 (pend_rx || pend_to)) ||
                (s_nxt.ie[serial_port_pkg::ie_tx] && pend_tx) ||
                (s_nxt.ie[serial_port_pkg::ie_ls] && pend_ls) ||
                (s_nxt.ie[serial_port_pkg::ie_ms] && pend_ms);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '0;
      s_r.ie <= serial_port_pkg::int_enable_rst;
      s_r.lc <= serial_port_pkg::line_control_rst;
      s_r.mc <= serial_port_pkg::modem_control_rst;
      s_r.tx_st <= serial_port_pkg::ser_idle;
      s_r.rx_st <= serial_port_pkg::ser_idle;
      s_r.txd <= 1'b1;
      s_r.rx_prev <= 1'b1;
      s_r.head_seen <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // outputs; the serial pin parks high during loop mode
  assign txd_o = s_r.mc[serial_port_pkg::mc_loop] ? 1'b1 : s_r.txd;
  assign rts_n_o = ~s_r.mc[serial_port_pkg::mc_rts];
  assign dtr_n_o = ~s_r.mc[serial_port_pkg::mc_dtr];
  assign irq_o = s_r.irq;
  assign wb_ack_o = s_r.ack;
  assign wb_dat_o = s_r.dat;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_tx_full_ignored;
    s_r.tx_cnt == (AW+1)'(DEPTH) && s_r.tx_st != serial_port_pkg::ser_idle
      |=> s_r.tx_cnt <= (AW+1)'(DEPTH);
  endproperty
  a_tx_full_ignored: assert property (p_tx_full_ignored)
    else $error("transmit count exceeds depth");

  property p_unbuffered_one;
    !s_r.lc[serial_port_pkg::lc_fifo_en] && s_r.rx_cnt <= 1 &&
      s_r.tx_cnt <= 1 |=> s_r.lc[serial_port_pkg::lc_fifo_en] ||
      (s_r.rx_cnt <= 1 && s_r.tx_cnt <= 1);
  endproperty
  a_unbuffered_one: assert property (p_unbuffered_one)
    else $error("unbuffered path holds more than one character");

  property p_idle_high;
    s_r.tx_st == serial_port_pkg::ser_idle &&
      !s_r.lc[serial_port_pkg::lc_break] |-> s_r.txd;
  endproperty
  a_idle_high: assert property (p_idle_high)
    else $error("serial output low while idle");

  property p_start_low;
    $rose(s_r.tx_st == serial_port_pkg::ser_start) &&
      !s_r.lc[serial_port_pkg::lc_break] |-> !s_r.txd;
  endproperty
  a_start_low: assert property (p_start_low)
    else $error("start bit not driven low");

  property p_bit_hold;
    s_r.tx_st == serial_port_pkg::ser_data && $changed(s_r.tx_bit)
      |-> $past(s_r.tx_tk) == serial_port_pkg::ticks_last;
  endproperty
  a_bit_hold: assert property (p_bit_hold)
    else $error("transmit bit advanced before sixteen enables");

  property p_tx_int;
    s_r.ie[serial_port_pkg::ie_tx] && s_r.tx_cnt == '0 |-> s_r.irq;
  endproperty
  a_tx_int: assert property (p_tx_int)
    else $error("transmit interrupt missing while buffer empty");

  property p_rx_trig;
    s_r.ie[serial_port_pkg::ie_rx] && s_r.rx_cnt != '0 &&
      !s_r.lc[serial_port_pkg::lc_fifo_en] |-> s_r.irq;
  endproperty
  a_rx_trig: assert property (p_rx_trig)
    else $error("receive interrupt missing with a character held");

  property p_to_hold;
    s_r.to_flag && s_nxt.rx_cnt != '0 |=> s_r.to_flag;
  endproperty
  a_to_hold: assert property (p_to_hold)
    else $error("time-out dropped while buffer not empty");

  property p_ms_int;
    s_r.ie[serial_port_pkg::ie_ms] && s_r.msd != '0 |-> s_r.irq;
  endproperty
  a_ms_int: assert property (p_ms_int)
    else $error("modem interrupt missing on flagged change");

  property p_ack_pulse;
    s_r.ack |=> !s_r.ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("acknowledge longer than one cycle");
endmodule

/* serial_peer.sv */
`timescale 1ns/1ps
// =====================================================
// far-side serial device: frames paced by the 16x tick
module serial_peer (
  // clock and tick
  input wire logic clk_i,
  input wire logic tick_i,
  // serial line
  input wire logic txd_i,
  output logic rxd_o
);
  // line idles high between frames
  initial rxd_o = 1'b1;

  task automatic hold_ticks(input int n);
    int k;
    k = 0;
    while (k < n) begin
      @(posedge clk_i);
      if (tick_i === 1'b1) k++;
    end
  endtask

  task automatic send_char(input logic [7:0] d, input int len,
                           input logic par_en, input logic par_bit);
    int i;
    rxd_o <= 1'b0;
    hold_ticks(16);
    for (i = 0; i < len; i++) begin
      rxd_o <= d[i];
      hold_ticks(16);
    end
    if (par_en) begin
      rxd_o <= par_bit;
      hold_ticks(16);
    end
    rxd_o <= 1'b1;
    hold_ticks(16);
  endtask

  // samples mid-bit: 8 ticks into start, then every 16
  task automatic recv_char(output logic [7:0] d, output logic ok);
    int i;
    i = 0;
    while (txd_i !== 1'b0 && i < 2000) begin
      @(posedge clk_i);
      i++;
    end
    hold_ticks(8);
    ok = (txd_i === 1'b0);
    for (i = 0; i < 8; i++) begin
      hold_ticks(16);
      d[i] = txd_i;
    end
    hold_ticks(16);
    ok = ok & (txd_i === 1'b1);
  endtask
endmodule

/* tb.sv */
`timescale 1ns/1ps
module tb;
  localparam logic [7:0] a_data = serial_port_pkg::data_adr;
  localparam logic [7:0] a_ie = serial_port_pkg::int_enable_adr;
  localparam logic [7:0] a_lc = serial_port_pkg::line_control_adr;
  localparam logic [7:0] a_ls = serial_port_pkg::line_status_adr;
  localparam logic [7:0] a_ms = serial_port_pkg::modem_status_adr;
  localparam logic [7:0] a_mc = serial_port_pkg::modem_control_adr;
  localparam logic [7:0] a_ip = serial_port_pkg::int_pending_adr;
  logic clk_i, rst_i, tick, wb_cyc, wb_stb, wb_we, wb_ack;
  logic [7:0] wb_adr, c0, c1;
  logic [31:0] wb_wdat, wb_rdat, rd;
  logic rxd, txd, cts_n, dsr_n, ring_n, dcd_n, irq, ok0, ok1;
  logic rts_n, dtr_n;
  int err_count = 0;
  int check_count = 0;

  serial_port serial_port_i (
    .clk_i(clk_i), .rst_i(rst_i), .bit_rate_tick_i(tick),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .rxd_i(rxd), .txd_o(txd),
    .cts_n_i(cts_n), .dsr_n_i(dsr_n), .ring_indicate_n_i(ring_n),
    .dcd_n_i(dcd_n), .rts_n_o(rts_n), .dtr_n_o(dtr_n), .irq_o(irq)
  );

  serial_peer serial_peer_i (
    .clk_i(clk_i), .tick_i(tick), .txd_i(txd), .rxd_o(rxd)
  );

  // =====================================================
  // clock, 16x tick every second cycle to keep runs short
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) tick <= ~tick;

  // =====================================================
  // bus and compare helpers
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_wdat <= d;
    @(posedge clk_i);
    // only the watchdog ends a wait for the answer
    while (wb_ack !== 1'b1) begin
      @(posedge clk_i);
    end
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got,
               exp);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // =====================================================
  // scenarios
  task automatic t_reset;
    wb(1'b0, a_ls, 32'h0);
    check(rd, 32'h60, "status after reset");
    check({31'h0, irq}, 32'h0, "irq masked after reset");
    wb(1'b0, 8'h1c, 32'h0);
    check(rd, 32'h0, "unmapped read");
  endtask

  task automatic t_tx;
    wb(1'b1, a_ie, 32'h2);
    repeat (2) @(posedge clk_i);
    check({31'h0, irq}, 32'h1, "tx empty irq");
    fork
      begin
        serial_peer_i.recv_char(c0, ok0);
        serial_peer_i.recv_char(c1, ok1);
      end
      begin
        wb(1'b1, a_data, 32'ha5);
        wb(1'b1, a_data, 32'h3c);
        repeat (2) @(posedge clk_i);
        check({31'h0, irq}, 32'h0, "irq after write");
      end
    join
    check({24'h0, c0}, 32'ha5, "first char lsb first");
    check({24'h0, c1}, 32'h3c, "second char");
    check({30'h0, ok0, ok1}, 32'h3, "start and stop");
    repeat (40) @(posedge clk_i);
    check({31'h0, txd}, 32'h1, "idle line high");
    check({31'h0, irq}, 32'h1, "irq when drained");
    wb(1'b1, a_ie, 32'h0);
  endtask

  // seven data bits, all ones on the wire
  task automatic t_rx;
    wb(1'b1, a_lc, 32'h2);
    serial_peer_i.send_char(8'hff, 7, 1'b0, 1'b0);
    repeat (4) @(posedge clk_i);
    wb(1'b0, a_ls, 32'h0);
    check(rd, 32'h61, "ready set");
    wb(1'b0, a_data, 32'h0);
    check(rd, 32'h7f, "upper bit zero");
    wb(1'b0, a_ls, 32'h0);
    check(rd, 32'h60, "ready cleared");
  endtask

  // even parity, parity bit sent wrong
  task automatic t_parity;
    wb(1'b1, a_lc, 32'h1b);
    wb(1'b1, a_ie, 32'h4);
    serial_peer_i.send_char(8'h01, 8, 1'b1, 1'b0);
    repeat (4) @(posedge clk_i);
    check({31'h0, irq}, 32'h1, "line status irq");
    wb(1'b0, a_ls, 32'h0);
    check(rd, 32'he5, "parity error status");
    check({31'h0, irq}, 32'h0, "status read clears irq");
    wb(1'b0, a_data, 32'h0);
    check(rd, 32'h01, "errored char data");
    wb(1'b0, a_ls, 32'h0);
    check(rd, 32'h60, "error summary gone");
  endtask

  task automatic t_modem;
    wb(1'b1, a_ie, 32'h8);
    wb(1'b0, a_ms, 32'h0);
    cts_n <= 1'b0;
    repeat (4) @(posedge clk_i);
    check({31'h0, irq}, 32'h1, "modem irq");
    wb(1'b0, a_ms, 32'h0);
    check(rd & 32'h0f, 32'h1, "cts change flag");
    repeat (2) @(posedge clk_i);
    check({31'h0, irq}, 32'h0, "irq cleared by read");
    ring_n <= 1'b0;
    repeat (4) @(posedge clk_i);
    wb(1'b0, a_ms, 32'h0);
    check(rd & 32'h0f, 32'h0, "ring leading edge");
    ring_n <= 1'b1;
    repeat (4) @(posedge clk_i);
    wb(1'b0, a_ms, 32'h0);
    check(rd & 32'h0f, 32'h4, "ring trailing edge");
  endtask

  // buffered, trigger of four; three characters then silence
  task automatic t_fifo;
    wb(1'b1, a_ie, 32'h1);
    wb(1'b1, a_lc, 32'hc3);
    serial_peer_i.send_char(8'h11, 8, 1'b0, 1'b0);
    serial_peer_i.send_char(8'h22, 8, 1'b0, 1'b0);
    serial_peer_i.send_char(8'h33, 8, 1'b0, 1'b0);
    repeat (1200) @(posedge clk_i);
    check({31'h0, irq}, 32'h0, "no irq below trigger");
    repeat (100) @(posedge clk_i);
    check({31'h0, irq}, 32'h1, "time-out irq");
    wb(1'b0, a_ip, 32'h0);
    check(rd, 32'h0e, "pending causes");
    wb(1'b0, a_data, 32'h0);
    check(rd, 32'h11, "first buffered");
    wb(1'b0, a_data, 32'h0);
    check(rd, 32'h22, "second buffered");
    check({31'h0, irq}, 32'h1, "time-out held");
    wb(1'b0, a_data, 32'h0);
    check(rd, 32'h33, "third buffered");
    check({31'h0, irq}, 32'h0, "time-out cleared when empty");
  endtask

  // break on the pin, then the line looped back inside
  task automatic t_loop;
    check({30'h0, rts_n, dtr_n}, 32'h3, "outputs idle");
    wb(1'b1, a_mc, 32'h03);
    check({30'h0, rts_n, dtr_n}, 32'h0, "outputs on");
    wb(1'b1, a_lc, 32'h23);
    check({31'h0, txd}, 32'h0, "break on the pin");
    wb(1'b1, a_mc, 32'h13);
    repeat (400) @(posedge clk_i);
    wb(1'b0, a_ls, 32'h0);
    check(rd, 32'hf9, "break looped back");
    wb(1'b1, a_lc, 32'h03);
    wb(1'b0, a_data, 32'h0);
    check(rd, 32'h0, "break char data");
    wb(1'b1, a_data, 32'h5a);
    repeat (100) @(posedge clk_i);
    check({31'h0, txd}, 32'h1, "pin parked in loop");
    repeat (300) @(posedge clk_i);
    wb(1'b0, a_data, 32'h0);
    check(rd, 32'h5a, "looped character");
  endtask

  // =====================================================
  // main sequence and watchdog
  initial begin
    rst_i = 1'b1;
    tick = 1'b0;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_wdat = 32'h0;
    cts_n = 1'b1;
    dsr_n = 1'b1;
    ring_n = 1'b1;
    dcd_n = 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset;
    t_tx;
    t_rx;
    t_parity;
    t_modem;
    t_fifo;
    t_loop;
    end_of_test;
  end

  // run needs about 5000 cycles; allow six times that
  initial begin
    #300000;
    err_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    end_of_test;
  end
endmodule
